//--- src/boot_cfg_pkg.sv
// Shared constants, types and encodings for the boot configuration access block
package boot_cfg_pkg;

  // Clock and internal write timing
  localparam int unsigned CLK_PERIOD_NS     = 40;
  localparam int unsigned NV_WRITE_TIME_NS  = 100_000;
  localparam logic [11:0] NV_WRITE_CYCLES   =
    12'(NV_WRITE_TIME_NS / CLK_PERIOD_NS);
  localparam logic [11:0] NV_WRITE_LAST     = NV_WRITE_CYCLES - 12'h001;

  // Serial command opcodes
  localparam logic [7:0] WRITE_ENABLE_OP    = 8'h06;
  localparam logic [7:0] STATUS_READ_OP     = 8'h05;
  localparam logic [7:0] READ_BOOT_CFG_OP   = 8'h14;
  localparam logic [7:0] WRITE_BOOT_CFG_OP  = 8'h15;

  // Frame bit counts
  localparam logic [5:0] OPCODE_BITS        = 6'h08;
  localparam logic [5:0] CFG_DATA_BITS      = 6'h20;
  localparam logic [5:0] CFG_OVERRUN        = 6'h21;

  // Device status byte layout
  localparam int unsigned STAT_BUSY_BIT     = 0;
  localparam int unsigned STAT_LATCH_BIT    = 1;

  // Boot configuration field positions and reset value
  localparam int unsigned CFG_ENABLE_POS    = 0;
  localparam int unsigned CFG_DELAY_POS     = 1;
  localparam int unsigned CFG_ADDR_POS      = 5;
  localparam logic [31:0] BOOT_CFG_RESET    = 32'h0000_0000;

  // Wishbone register byte offsets
  localparam logic [7:0] CTRL_OFS           = 8'h00;
  localparam logic [7:0] STATUS_OFS         = 8'h04;
  localparam logic [7:0] BOOT_CFG_OFS       = 8'h08;
  localparam int unsigned CTRL_QUAD_BIT     = 0;
  localparam logic        CTRL_QUAD_RESET   = 1'b0;

  // Non-volatile boot configuration word
  typedef struct packed {
    logic [26:0] start_address;
    logic [3:0]  start_delay;
    logic        feature_enable;
  } boot_cfg_t;

  // Command sequencer states, Gray ordered along the usual path
  typedef enum logic [2:0] {
    ST_IDLE     = 3'h0,
    ST_OPCODE   = 3'h1,
    ST_DATA_IN  = 3'h3,
    ST_CFG_OUT  = 3'h2,
    ST_STAT_OUT = 3'h6,
    ST_WR_ENABLE = 3'h7,
    ST_IGNORE   = 3'h5
  } cmd_state_t;

endpackage

//--- src/pin_sync.sv
// Two-stage synchroniser for the serial pins
`timescale 1ns/1ps
module pin_sync
  import boot_cfg_pkg::*;
#(
  parameter int unsigned W = 6
) (
  input  wire logic         clk_i,
  input  wire logic         arst_n_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  ////////////////////////////////////////////////////////////////////////////
  // One flip-flop pair per pin
  genvar gi;
  generate
    for (gi = 0; gi < W; gi++) begin : g_bit
      logic meta_reg;
      logic sync_reg;
      always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          meta_reg <= 1'b1;
          sync_reg <= 1'b1;
        end else begin
          meta_reg <= async_i[gi];
          sync_reg <= meta_reg;
        end
      end
      assign sync_o[gi] = sync_reg;
    end
  endgenerate

endmodule // pin_sync

//--- src/nv_write_timer.sv
// Timer for the internal non-volatile register write
`timescale 1ns/1ps
module nv_write_timer
  import boot_cfg_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic arst_n_i,
  input  wire logic start_i,
  output logic      busy_o,
  output logic      done_o
);

  logic [11:0] cnt_reg;
  logic        busy_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Last cycle of the write
  assign done_o = busy_reg && (cnt_reg == NV_WRITE_LAST);
  assign busy_o = busy_reg;

  // Busy for exactly NV_WRITE_CYCLES cycles
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      busy_reg <= 1'b0;
      cnt_reg  <= 12'h000;
    end else if (start_i && !busy_reg) begin
      busy_reg <= 1'b1;
      cnt_reg  <= 12'h000;
    end else if (done_o) begin
      busy_reg <= 1'b0;
    end else if (busy_reg) begin
      cnt_reg  <= cnt_reg + 12'h001;
    end
  end

endmodule // nv_write_timer

//--- src/boot_cfg_access.sv
// Serial command handler for the boot configuration register
//
// How it works
// - Read command returns 32 bits, low byte first, each byte MSB first.
// - Further clocks with chip enable low repeat the 32-bit word.
// - Write command accepted only while the write enable latch is set.
// - Chip enable rising anywhere but after bit 32 discards the write.
// - Valid write starts the internal write at chip enable rising.
// - Write in progress reads 1 during the write, 0 afterwards.
// - Finished write clears the write enable latch.
// - Word holds start address, 4-bit delay count and enable bit.
`timescale 1ns/1ps
module boot_cfg_access
  import boot_cfg_pkg::*;
(
  input  wire logic        SYS_CLK_I,
  input  wire logic        ARST_N_I,
  input  wire logic        SCK_I,
  input  wire logic        CE_N_I,
  input  wire logic [3:0]  IO_I,
  output logic      [3:0]  IO_O,
  output logic      [3:0]  IO_OE_N_O,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  output boot_cfg_t        BOOT_CFG_O,
  output logic             WRITE_IN_PROGRESS_O
);

  logic [5:0]  pins_s;
  logic        sck_s;
  logic        ce_n_s;
  logic [3:0]  io_s;
  logic        sck_d_reg;
  logic        ce_d_reg;
  logic        sck_rise;
  logic        sck_fall;
  logic        ce_rise;
  logic        ce_fall;
  cmd_state_t  state_reg;
  cmd_state_t  state_next;
  cmd_state_t  op_state;
  logic [5:0]  bit_cnt_reg;
  logic [5:0]  cnt_step;
  logic [5:0]  cnt_add;
  logic [5:0]  cnt_sat;
  logic [31:0] in_shift_reg;
  logic [31:0] in_next;
  logic [31:0] rx_word;
  logic [7:0]  opcode;
  logic        op_done;
  logic        shifting_in;
  logic        out_state;
  logic [4:0]  out_cnt_reg;
  logic [4:0]  out_step;
  logic [3:0]  dout_reg;
  logic [3:0]  oe_n_reg;
  logic [3:0]  dout_next;
  logic [3:0]  oe_n_next;
  logic [31:0] cfg_bits;
  logic [7:0]  stat_byte;
  logic        rd_bit;
  logic [3:0]  rd_nib;
  logic        st_bit;
  logic [3:0]  st_nib;
  logic        tx_bit;
  logic [3:0]  tx_nib;
  boot_cfg_t   cfg_reg;
  boot_cfg_t   pending_reg;
  logic        write_enable_latch_reg;
  logic        latch_set;
  logic        write_in_progress;
  logic        write_go;
  logic        timer_done;
  logic        quad_reg;
  logic        wb_req;
  logic        ack_reg;
  logic [31:0] wb_dat_reg;
  logic [31:0] rd_mux;
  logic        sel_ctrl;
  logic        sel_status;
  logic        sel_cfg;
  logic [11:0] busy_len_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detection
  pin_sync #(.W(6)) u_sync (
    .clk_i    (SYS_CLK_I),
    .arst_n_i (ARST_N_I),
    .async_i  ({IO_I, CE_N_I, SCK_I}),
    .sync_o   (pins_s)
  );

  assign sck_s    = pins_s[0];
  assign ce_n_s   = pins_s[1];
  assign io_s     = pins_s[5:2];
  assign sck_rise = sck_s & ~sck_d_reg & ~ce_n_s;
  assign sck_fall = ~sck_s & sck_d_reg & ~ce_n_s;
  assign ce_rise  = ce_n_s & ~ce_d_reg;
  assign ce_fall  = ~ce_n_s & ce_d_reg;

  // Delayed copies for edge detection
  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      sck_d_reg <= 1'b0;
      ce_d_reg  <= 1'b1;
    end else begin
      sck_d_reg <= sck_s;
      ce_d_reg  <= ce_n_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input shifting, one or four lanes per clock
  assign cnt_step    = quad_reg ? 6'h04 : 6'h01;
  assign cnt_add     = bit_cnt_reg + cnt_step;
  assign cnt_sat     = (cnt_add > CFG_DATA_BITS) ? CFG_OVERRUN : cnt_add;
  assign in_next     = quad_reg ? {in_shift_reg[27:0], io_s}
                                : {in_shift_reg[30:0], io_s[0]};
  assign opcode      = in_next[7:0];
  assign shifting_in = (state_reg == ST_OPCODE) | (state_reg == ST_DATA_IN);
  assign op_done     = sck_rise & (state_reg == ST_OPCODE)
                     & (cnt_add == OPCODE_BITS);
  // First byte received is the low byte
  assign rx_word     = {in_shift_reg[7:0], in_shift_reg[15:8],
                        in_shift_reg[23:16], in_shift_reg[31:24]};

  // Opcode decode; busy device answers only status polls
  // Write accepted only with latch set
  assign op_state =
    (opcode == STATUS_READ_OP)   ? ST_STAT_OUT  :
    write_in_progress            ? ST_IGNORE    :
    (opcode == READ_BOOT_CFG_OP) ? ST_CFG_OUT   :
    (opcode == WRITE_ENABLE_OP)  ? ST_WR_ENABLE :
    ((opcode == WRITE_BOOT_CFG_OP) && write_enable_latch_reg) ? ST_DATA_IN :
                                   ST_IGNORE;

  // Sequencer next state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:     if (ce_fall) state_next = ST_OPCODE;
      ST_OPCODE:   begin
        if (ce_rise) state_next = ST_IDLE;
        else if (op_done) state_next = op_state;
      end
      ST_DATA_IN, ST_CFG_OUT, ST_STAT_OUT, ST_WR_ENABLE, ST_IGNORE: begin
        if (ce_rise) state_next = ST_IDLE;
      end
      default:     state_next = ST_IDLE;
    endcase
  end

  // State, bit count and input shifter
  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      state_reg    <= ST_IDLE;
      bit_cnt_reg  <= 6'h00;
      in_shift_reg <= 32'h0000_0000;
    end else begin
      state_reg <= state_next;
      if (ce_fall || op_done) bit_cnt_reg <= 6'h00;
      else if (sck_rise && shifting_in) bit_cnt_reg <= cnt_sat;
      if (sck_rise && shifting_in) in_shift_reg <= in_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output selection, low byte first and MSB first within a byte
  assign cfg_bits  = cfg_reg;
  assign stat_byte = {6'h00, write_enable_latch_reg, write_in_progress};
  // Byte order and bit order of read data
  assign rd_bit    = cfg_bits[{out_cnt_reg[4:3], ~out_cnt_reg[2:0]}];
  assign rd_nib    = cfg_bits[{out_cnt_reg[4:3], ~out_cnt_reg[2], 2'b00} +: 4];
  assign st_bit    = stat_byte[~out_cnt_reg[2:0]];
  assign st_nib    = out_cnt_reg[2] ? stat_byte[3:0] : stat_byte[7:4];
  assign tx_bit    = (state_reg == ST_CFG_OUT) ? rd_bit : st_bit;
  assign tx_nib    = (state_reg == ST_CFG_OUT) ? rd_nib : st_nib;
  assign out_state = (state_reg == ST_CFG_OUT) | (state_reg == ST_STAT_OUT);
  assign out_step  = quad_reg ? 5'h04 : 5'h01;
  assign dout_next = quad_reg ? tx_nib : {2'b00, tx_bit, 1'b0};
  assign oe_n_next = quad_reg ? 4'h0 : 4'hD;

  // Drive on falling clock; index wraps to repeat the word
  // Five-bit index wraps every 32 bits
  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      out_cnt_reg <= 5'h00;
      dout_reg    <= 4'h0;
      oe_n_reg    <= 4'hF;
    end else if (op_done || ce_rise) begin
      out_cnt_reg <= 5'h00;
      oe_n_reg    <= 4'hF;
    end else if (sck_fall && out_state) begin
      out_cnt_reg <= out_cnt_reg + out_step;
      dout_reg    <= dout_next;
      oe_n_reg    <= oe_n_next;
    end
  end

  assign IO_O      = dout_reg;
  assign IO_OE_N_O = oe_n_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Write command completion and internal write
  // Only an exact 32-bit frame starts the write
  assign write_go = ce_rise & (state_reg == ST_DATA_IN)
                  & (bit_cnt_reg == CFG_DATA_BITS);
  assign latch_set = ce_rise & (state_reg == ST_WR_ENABLE);

  // Write timer starts at chip enable rising
  nv_write_timer u_timer (
    .clk_i    (SYS_CLK_I),
    .arst_n_i (ARST_N_I),
    .start_i  (write_go),
    .busy_o   (write_in_progress),
    .done_o   (timer_done)
  );

  // Latch, staged word and stored word
  // Latch cleared when write ends
  // Stored fields update at write end
  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      write_enable_latch_reg <= 1'b0;
      pending_reg <= BOOT_CFG_RESET;
      cfg_reg     <= BOOT_CFG_RESET;
    end else begin
      if (latch_set) write_enable_latch_reg <= 1'b1;
      else if (timer_done) write_enable_latch_reg <= 1'b0;
      if (write_go) pending_reg <= rx_word;
      if (timer_done) cfg_reg <= pending_reg;
    end
  end

  // Busy flag straight from the timer
  assign WRITE_IN_PROGRESS_O = write_in_progress;
  assign BOOT_CFG_O          = cfg_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone slave, one wait state
  assign wb_req     = WB_CYC_I & WB_STB_I & ~ack_reg;
  assign sel_ctrl   = (WB_ADR_I == CTRL_OFS);
  assign sel_status = (WB_ADR_I == STATUS_OFS);
  assign sel_cfg    = (WB_ADR_I == BOOT_CFG_OFS);
  assign rd_mux     = sel_ctrl   ? {31'h0000_0000, quad_reg}  :
                      sel_status ? {24'h00_0000, stat_byte}   :
                      sel_cfg    ? cfg_bits : 32'h0000_0000;

  // Acknowledge, read data and control bit
  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      ack_reg    <= 1'b0;
      wb_dat_reg <= 32'h0000_0000;
      quad_reg   <= CTRL_QUAD_RESET;
    end else begin
      ack_reg <= wb_req;
      if (wb_req) wb_dat_reg <= rd_mux;
      if (wb_req && WB_WE_I && WB_SEL_I[0] && sel_ctrl) begin
        quad_reg <= WB_DAT_I[CTRL_QUAD_BIT];
      end
    end
  end

  assign WB_ACK_O = ack_reg;
  assign WB_DAT_O = wb_dat_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) busy_len_reg <= 12'h000;
    else if (write_in_progress) busy_len_reg <= busy_len_reg + 12'h001;
    else busy_len_reg <= 12'h000;
  end

  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!ARST_N_I);

  property p_read_low_byte_first;
    sck_fall && state_reg == ST_CFG_OUT && !quad_reg && out_cnt_reg == 5'h00
      |=> IO_O[1] == cfg_bits[7] && IO_OE_N_O == 4'hD;
  endproperty
  a_read_low_byte_first: assert property (p_read_low_byte_first)
    else $error("first read bit is not bit 7 of low byte");

  property p_read_repeats;
    sck_fall && state_reg == ST_CFG_OUT && !quad_reg && out_cnt_reg == 5'h1F
      && !ce_rise |=> out_cnt_reg == 5'h00 && IO_O[1] == cfg_bits[24];
  endproperty
  a_read_repeats: assert property (p_read_repeats)
    else $error("read word does not wrap to its start");

  property p_write_needs_latch;
    write_go |-> write_enable_latch_reg ##1 write_in_progress;
  endproperty
  a_write_needs_latch: assert property (p_write_needs_latch)
    else $error("write started without write enable latch");

  property p_short_frame_dropped;
    ce_rise && state_reg == ST_DATA_IN && bit_cnt_reg != CFG_DATA_BITS
      |-> !write_go ##1 state_reg == ST_IDLE;
  endproperty
  a_short_frame_dropped: assert property (p_short_frame_dropped)
    else $error("incomplete write frame was executed");

  property p_write_starts;
    ce_rise && state_reg == ST_DATA_IN && bit_cnt_reg == CFG_DATA_BITS
      |=> write_in_progress && pending_reg == $past(rx_word);
  endproperty
  a_write_starts: assert property (p_write_starts)
    else $error("valid write did not start internal write");

  property p_busy_length;
    timer_done |-> write_in_progress && busy_len_reg == NV_WRITE_LAST
      ##1 !write_in_progress;
  endproperty
  a_busy_length: assert property (p_busy_length)
    else $error("write in progress has wrong length");

  property p_latch_cleared;
    timer_done |=> !write_enable_latch_reg && !WRITE_IN_PROGRESS_O;
  endproperty
  a_latch_cleared: assert property (p_latch_cleared)
    else $error("write enable latch not cleared after write");

  property p_fields_loaded;
    timer_done |=> BOOT_CFG_O.start_delay == $past(pending_reg.start_delay)
      && BOOT_CFG_O.feature_enable == $past(pending_reg.feature_enable);
  endproperty
  a_fields_loaded: assert property (p_fields_loaded)
    else $error("boot fields not updated at write end");

  property p_unlatched_write_ignored;
    op_done && opcode == WRITE_BOOT_CFG_OP && !write_enable_latch_reg
      |=> state_reg == ST_IGNORE && !write_enable_latch_reg
      && $stable(cfg_reg);
  endproperty
  a_unlatched_write_ignored: assert property (p_unlatched_write_ignored)
    else $error("write without latch was not ignored");

  c_read_wraps: cover property (sck_fall && state_reg == ST_CFG_OUT
                                && out_cnt_reg == 5'h1F);
  c_write_done: cover property (timer_done);
  c_poll_busy:  cover property (op_done && write_in_progress
                                && opcode == STATUS_READ_OP);

endmodule // boot_cfg_access

//--- verification/spi_host_model.sv
// Host serial port model that frames commands for the block
`timescale 1ns/1ps
module spi_host_model
  import boot_cfg_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic [3:0] io_i,
  output logic            sck_o,
  output logic            ce_n_o,
  output logic      [3:0] io_o,
  output logic      [3:0] io_en_o
);
  localparam int HALF = 5;  // System cycles per serial clock phase

  // Idle frame: clock parked low, chip enable high, lanes released
  initial begin
    sck_o   = 1'b0;
    ce_n_o  = 1'b1;
    io_o    = 4'h0;
    io_en_o = 4'h0;
  end

  function automatic int bpos(input int k);
    return (k / 32) * 32 + ((k % 32) / 8) * 8 + 7 - (k % 8);
  endfunction

  // One frame: opcode, then nbits of data out and in
  task automatic xfer(input logic [7:0] op, input logic [63:0] wd,
                      input int nbits, input bit quad, input bit drv,
                      output logic [63:0] rd);
    int         w;
    int         k;
    int         j;
    logic [3:0] nib;
    w  = quad ? 4 : 1;
    rd = '0;
    @(posedge clk_i);
    ce_n_o <= 1'b0;
    for (k = 0; k < 8 + nbits; k += w) begin
      nib = 4'h0;
      for (j = 0; j < w; j++) begin
        nib[w-1-j] = (k + j < 8) ? op[7-(k+j)] : wd[bpos(k+j-8)];
      end
      io_o    <= nib;
      io_en_o <= (k < 8 || drv) ? (quad ? 4'hF : 4'h1) : 4'h0;
      repeat (HALF) @(posedge clk_i);
      sck_o <= 1'b1;
      for (j = 0; j < w && k >= 8; j++) begin
        rd[bpos(k+j-8)] = quad ? io_i[w-1-j] : io_i[1];
      end
      repeat (HALF) @(posedge clk_i);
      sck_o <= 1'b0;
    end
    repeat (HALF) @(posedge clk_i);
    // chip enable rises after the last bit
    ce_n_o  <= 1'b1;
    io_en_o <= 4'h0;
    repeat (2 * HALF) @(posedge clk_i);
  endtask

endmodule // spi_host_model

//--- verification/test_boot_cfg_access.sv
// Self-checking bench for the boot configuration access block
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin \
  fails++; $display("[ERR] %s exp %h got %h", nm, ex, got); end end
module test_boot_cfg_access
  import boot_cfg_pkg::*;
;
  logic        sys_clk;
  logic        arst_n;
  logic        wb_cyc;
  logic        wb_stb;
  logic        wb_we;
  logic [7:0]  wb_adr;
  logic [3:0]  wb_sel;
  logic [31:0] wb_dat_w;
  logic [31:0] wb_dat_r;
  logic        wb_ack;
  logic [3:0]  io_o;
  logic [3:0]  io_oe_n;
  boot_cfg_t   cfg;
  logic        busy;
  logic        sck;
  logic        ce_n;
  logic [3:0]  h_io;
  logic [3:0]  h_en;
  logic [3:0]  flt;
  wire  [3:0]  io_w;
  logic [63:0] rd;
  logic [31:0] r;
  boot_cfg_t   w1;
  boot_cfg_t   w2;
  int          fails;
  int          compares;
  int          cyc_cnt;
  int          busy_len;
  int          last_len;
  int          i;

  // Lane level: device, else host, else a toggling float
  assign io_w = (~io_oe_n & io_o) | (io_oe_n & h_en & h_io)
              | (io_oe_n & ~h_en & flt);

  boot_cfg_access boot_cfg_access_i (
    .SYS_CLK_I(sys_clk), .ARST_N_I(arst_n), .SCK_I(sck), .CE_N_I(ce_n),
    .IO_I(io_w), .IO_O(io_o), .IO_OE_N_O(io_oe_n), .WB_CYC_I(wb_cyc),
    .WB_STB_I(wb_stb), .WB_WE_I(wb_we), .WB_ADR_I(wb_adr),
    .WB_SEL_I(wb_sel), .WB_DAT_I(wb_dat_w), .WB_DAT_O(wb_dat_r),
    .WB_ACK_O(wb_ack), .BOOT_CFG_O(cfg), .WRITE_IN_PROGRESS_O(busy)
  );

  spi_host_model spi_host_model_i (
    .clk_i(sys_clk), .io_i(io_w), .sck_o(sck), .ce_n_o(ce_n),
    .io_o(h_io), .io_en_o(h_en)
  );

  // Clock, float pattern, busy length and timeout
  initial sys_clk = 1'b0;
  always #20 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    flt     <= ~flt;
    cyc_cnt <= cyc_cnt + 1;
    if (busy === 1'b1) begin
      busy_len <= busy_len + 1;
    end else if (busy_len != 0) begin
      last_len <= busy_len;
      busy_len <= 0;
    end
    if (cyc_cnt == 40000) begin
      fails++;
      final_report;
    end
  end

  task automatic final_report;
    $display("Checks %0d, mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Classic single Wishbone cycle
  task automatic wb(input logic we, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    @(posedge sys_clk);
    wb_cyc   <= 1'b1;
    wb_stb   <= 1'b1;
    wb_we    <= we;
    wb_adr   <= a;
    wb_dat_w <= d;
    wb_sel   <= 4'hF;
    do @(posedge sys_clk); while (wb_ack !== 1'b1);
    q = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we  <= 1'b0;
  endtask

  // Bounded wait for the internal write to end
  task automatic wait_idle;
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 4000) begin
      @(posedge sys_clk);
      n++;
    end
    `CHK("busy_end", 1'b0, busy)
  endtask

  // Main sequence
  initial begin
    arst_n = 1'b0;
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we = 1'b0;
    wb_adr = 8'h00;
    wb_sel = 4'h0;
    wb_dat_w = 32'h0000_0000;
    flt = 4'h5;
    fails = 0;
    compares = 0;
    cyc_cnt = 0;
    busy_len = 0;
    last_len = 0;
    w1 = '{27'h2A5_A5C3, 4'hF, 1'b1};
    w2 = '{27'h0C3_0F96, 4'h6, 1'b0};
    repeat (20) @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    `CHK("oe_idle", 4'hF, io_oe_n)
    `CHK("cfg_reset", BOOT_CFG_RESET, cfg)
    wb(1'b1, STATUS_OFS, 32'hFFFF_FFFF, r);
    for (i = 0; i < 4; i++) begin
      wb(1'b0, 8'(4 * i), 32'h0000_0000, r);
      `CHK("reg_reset", 32'h0000_0000, r)
    end
    // Write with the latch clear is ignored
    spi_host_model_i.xfer(WRITE_BOOT_CFG_OP, {32'h0, w1}, 32, 0, 1, rd);
    `CHK("busy_nolatch", 1'b0, busy)
    `CHK("cfg_nolatch", BOOT_CFG_RESET, cfg)
    wb(1'b0, STATUS_OFS, 32'h0000_0000, r);
    `CHK("stat_nolatch", 32'h0000_0000, r)
    // Short and long frames are discarded
    spi_host_model_i.xfer(WRITE_ENABLE_OP, 64'h0, 0, 0, 1, rd);
    for (i = 31; i <= 33; i += 2) begin
      spi_host_model_i.xfer(WRITE_BOOT_CFG_OP, {w1, w1}, i, 0, 1, rd);
      `CHK("busy_badlen", 1'b0, busy)
      `CHK("cfg_badlen", BOOT_CFG_RESET, cfg)
    end
    wb(1'b0, STATUS_OFS, 32'h0000_0000, r);
    `CHK("stat_latch", 32'h0000_0002, r)
    // Valid write, polled while busy
    spi_host_model_i.xfer(WRITE_BOOT_CFG_OP, {32'h0, w1}, 32, 0, 1, rd);
    `CHK("busy_start", 1'b1, busy)
    spi_host_model_i.xfer(STATUS_READ_OP, 64'h0, 8, 0, 0, rd);
    `CHK("stat_busy", 8'h03, rd[7:0])
    wait_idle;
    repeat (2) @(posedge sys_clk);
    `CHK("busy_len", int'(NV_WRITE_CYCLES), last_len)
    `CHK("cfg_written", w1, cfg)
    wb(1'b0, STATUS_OFS, 32'h0000_0000, r);
    `CHK("latch_clr", 32'h0000_0000, r)
    wb(1'b0, BOOT_CFG_OFS, 32'h0000_0000, r);
    `CHK("cfg_reg", 32'(w1), r)
    // Serial read repeats the word
    spi_host_model_i.xfer(READ_BOOT_CFG_OP, 64'h0, 64, 0, 0, rd);
    `CHK("read_first", 32'(w1), rd[31:0])
    `CHK("read_again", 32'(w1), rd[63:32])
    `CHK("oe_after", 4'hF, io_oe_n)
    // Second write needs a new enable
    spi_host_model_i.xfer(WRITE_BOOT_CFG_OP, {32'h0, w2}, 32, 0, 1, rd);
    `CHK("busy_relatch", 1'b0, busy)
    `CHK("cfg_kept", w1, cfg)
    // Quad lane write and read
    wb(1'b1, CTRL_OFS, 32'h0000_0001, r);
    wb(1'b0, CTRL_OFS, 32'h0000_0000, r);
    `CHK("ctrl_quad", 32'h0000_0001, r)
    spi_host_model_i.xfer(WRITE_ENABLE_OP, 64'h0, 0, 1, 1, rd);
    spi_host_model_i.xfer(WRITE_BOOT_CFG_OP, {32'h0, w2}, 32, 1, 1, rd);
    `CHK("busy_quad", 1'b1, busy)
    // Status poll over four lanes while busy
    spi_host_model_i.xfer(STATUS_READ_OP, 64'h0, 8, 1, 0, rd);
    `CHK("qstat_busy", 8'h03, rd[7:0])
    wait_idle;
    `CHK("cfg_quad", w2, cfg)
    spi_host_model_i.xfer(READ_BOOT_CFG_OP, 64'h0, 64, 1, 0, rd);
    `CHK("qread_first", 32'(w2), rd[31:0])
    `CHK("qread_again", 32'(w2), rd[63:32])
    wb(1'b1, CTRL_OFS, 32'h0000_0000, r);
    // Reset in mid-run clears the word and the latch
    spi_host_model_i.xfer(WRITE_ENABLE_OP, 64'h0, 0, 0, 1, rd);
    @(posedge sys_clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    `CHK("oe_rst2", 4'hF, io_oe_n)
    `CHK("cfg_rst2", BOOT_CFG_RESET, cfg)
    wb(1'b0, STATUS_OFS, 32'h0000_0000, r);
    `CHK("stat_rst2", 32'h0000_0000, r)
    final_report;
  end

endmodule // test_boot_cfg_access
